// ===== core/ddcor_top.sv
// Over-range detection with pin stretch and NCO preset selection for two down-converters.
`timescale 1ns/1ps
module ddcor_top
    import ddcor_pkg::*;
#(
    parameter int SAMPLE_W = 12,
    parameter int STRETCH_CNT_W = 11
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire ddcor_bus_t bus,
    output logic [7:0] rdata,
    input wire logic single_channel,
    input wire logic sample_valid,
    input wire logic signed [SAMPLE_W-1:0] sample_i_a,
    input wire logic signed [SAMPLE_W-1:0] sample_q_a,
    input wire logic signed [SAMPLE_W-1:0] sample_i_b,
    input wire logic signed [SAMPLE_W-1:0] sample_q_b,
    output logic [1:0] link_ctrl_a,
    output logic [1:0] link_ctrl_b,
    output logic range_flag_a_zero,
    output logic range_flag_a_one,
    output logic range_flag_b_zero,
    output logic range_flag_b_one,
    input wire logic [1:0] preset_pins_a,
    input wire logic [1:0] preset_pins_b,
    input wire ddcor_nco_t [DDCOR_NUM_PRESETS-1:0] presets_a,
    input wire ddcor_nco_t [DDCOR_NUM_PRESETS-1:0] presets_b,
    output logic [1:0] active_preset_a,
    output logic [1:0] active_preset_b,
    output logic [31:0] freq_word_a,
    output logic [31:0] phase_word_a,
    output logic [31:0] freq_word_b,
    output logic [31:0] phase_word_b,
    output logic [7:0] channel_binding,
    output logic irq
);

    // ****************************************
    // Register file
    // ****************************************
    logic [7:0] thr_i_r;
    logic [7:0] thr_q_r;
    logic [7:0] pin_cfg_r;
    logic [7:0] src_mode_r;
    logic [7:0] sel_r;
    logic [7:0] bind_r;
    logic [3:0] irq_stat_r;
    logic [3:0] irq_mask_r;
    logic [3:0] irq_stat_nxt;
    logic [7:0] rdata_nxt;
    logic [3:0] det;
    logic [3:0] stretch_out;

    wire wr_thr_i = bus.wr && bus.addr == DDCOR_OFF_THR_I;
    wire wr_thr_q = bus.wr && bus.addr == DDCOR_OFF_THR_Q;
    wire wr_pin_cfg = bus.wr && bus.addr == DDCOR_OFF_PIN_CFG;
    wire wr_src_mode = bus.wr && bus.addr == DDCOR_OFF_SRC_MODE;
    wire wr_sel = bus.wr && bus.addr == DDCOR_OFF_SEL;
    wire wr_bind = bus.wr && bus.addr == DDCOR_OFF_BIND;
    wire wr_stat = bus.wr && bus.addr == DDCOR_OFF_IRQ_STAT;
    wire wr_mask = bus.wr && bus.addr == DDCOR_OFF_IRQ_MASK;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            thr_i_r <= DDCOR_RST_THR_I;
            thr_q_r <= DDCOR_RST_THR_Q;
            pin_cfg_r <= DDCOR_RST_PIN_CFG;
            src_mode_r <= DDCOR_RST_SRC_MODE;
            sel_r <= DDCOR_RST_SEL;
            bind_r <= DDCOR_RST_BIND;
            irq_mask_r <= DDCOR_RST_ZERO[3:0];
        end else begin
            if (wr_thr_i) thr_i_r <= bus.wdata;
            if (wr_thr_q) thr_q_r <= bus.wdata;
            if (wr_pin_cfg) pin_cfg_r <= bus.wdata;
            if (wr_src_mode) src_mode_r <= bus.wdata;
            if (wr_sel) sel_r <= bus.wdata;
            if (wr_bind) bind_r <= bus.wdata;
            if (wr_mask) irq_mask_r <= bus.wdata[3:0];
        end
    end

    // Sticky status: a detection in the same cycle as a write-one clear wins.
    assign irq_stat_nxt = (irq_stat_r & ~(wr_stat ? bus.wdata[3:0] : 4'h0)) | det;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            irq_stat_r <= DDCOR_RST_ZERO[3:0];
        end else begin
            irq_stat_r <= irq_stat_nxt;
        end
    end

    assign irq = |(irq_stat_r & irq_mask_r);

    always_comb begin
        case (bus.addr)
            DDCOR_OFF_THR_I: rdata_nxt = thr_i_r;
            DDCOR_OFF_THR_Q: rdata_nxt = thr_q_r;
            DDCOR_OFF_PIN_CFG: rdata_nxt = pin_cfg_r;
            DDCOR_OFF_SRC_MODE: rdata_nxt = src_mode_r;
            DDCOR_OFF_SEL: rdata_nxt = sel_r;
            DDCOR_OFF_BIND: rdata_nxt = bind_r;
            DDCOR_OFF_IRQ_STAT: rdata_nxt = {4'h0, irq_stat_r};
            DDCOR_OFF_IRQ_MASK: rdata_nxt = {4'h0, irq_mask_r};
            default: rdata_nxt = DDCOR_RST_ZERO;
        endcase
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            rdata <= DDCOR_RST_ZERO;
        end else if (bus.rd) begin
            rdata <= rdata_nxt;
        end else begin
            rdata <= DDCOR_RST_ZERO;
        end
    end

    assign channel_binding = bind_r;

    // ****************************************
    // Over-range detection
    // ****************************************
    // The top eight magnitude bits are compared, so each threshold step is 1/256 of full scale.
    function automatic logic [7:0] ddcor_mag8(input logic signed [SAMPLE_W-1:0] s);
        logic [SAMPLE_W-1:0] m;
        m = s[SAMPLE_W-1] ? SAMPLE_W'(-s) : SAMPLE_W'(s);
        if (m[SAMPLE_W-1]) begin
            ddcor_mag8 = 8'hff;
        end else begin
            ddcor_mag8 = m[SAMPLE_W-2 -: 8];
        end
    endfunction

    logic [3:0] det_r;
    assign det[0] = sample_valid && ddcor_mag8(sample_i_a) >= thr_i_r;
    assign det[1] = sample_valid && ddcor_mag8(sample_q_a) >= thr_q_r;
    assign det[2] = sample_valid && ddcor_mag8(sample_i_b) >= thr_i_r;
    assign det[3] = sample_valid && ddcor_mag8(sample_q_b) >= thr_q_r;

    // Link bits go out regardless of the pin enable.
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            det_r <= DDCOR_RST_ZERO[3:0];
        end else begin
            det_r <= det;
        end
    end

    assign link_ctrl_a = det_r[1:0];
    assign link_ctrl_b = det_r[3:2];

    // ****************************************
    // Pin pulse stretch
    // ****************************************
    wire pin_en = pin_cfg_r[DDCOR_PIN_EN_BIT];
    wire [2:0] stretch_exp = pin_cfg_r[DDCOR_STRETCH_HI:DDCOR_STRETCH_LO];
    // The shift amount is four bits wide, because exponent seven plus three would wrap in three bits.
    wire [STRETCH_CNT_W-1:0] stretch_len =
        STRETCH_CNT_W'(1) << (4'(stretch_exp) + 4'(DDCOR_BASE_STRETCH_LOG2));

    genvar g;
    generate
        for (g = 0; g < DDCOR_NUM_FLAGS; g++) begin : g_stretch
            logic [STRETCH_CNT_W-1:0] cnt_r;
            logic pin_r;
            always_ff @(posedge ref_clk or posedge reset) begin
                if (reset) begin
                    cnt_r <= '0;
                    pin_r <= 1'b0;
                end else if (!pin_en) begin
                    cnt_r <= '0;
                    pin_r <= 1'b0;
                end else if (det[g]) begin
                    cnt_r <= stretch_len - STRETCH_CNT_W'(1);
                    pin_r <= 1'b1;
                end else if (cnt_r != '0) begin
                    cnt_r <= cnt_r - STRETCH_CNT_W'(1);
                end else begin
                    pin_r <= 1'b0;
                end
            end
            assign stretch_out[g] = pin_r;
        end
    endgenerate

    assign range_flag_a_zero = stretch_out[0];
    assign range_flag_a_one = stretch_out[1];
    assign range_flag_b_zero = stretch_out[2];
    assign range_flag_b_one = stretch_out[3];

    // ****************************************
    // NCO preset selection
    // ****************************************
    // Select pins come from off chip, so they pass three flops and change once stages two and three agree.
    logic [3:0] pin_s1_r;
    logic [3:0] pin_s2_r;
    logic [3:0] pin_s3_r;
    logic [3:0] pin_q_r;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            pin_s1_r <= DDCOR_RST_ZERO[3:0];
            pin_s2_r <= DDCOR_RST_ZERO[3:0];
            pin_s3_r <= DDCOR_RST_ZERO[3:0];
            pin_q_r <= DDCOR_RST_ZERO[3:0];
        end else begin
            pin_s1_r <= {preset_pins_b, preset_pins_a};
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
            if (pin_s2_r == pin_s3_r) pin_q_r <= pin_s3_r;
        end
    end

    ddcor_src_t src_mode;
    assign src_mode = ddcor_src_t'(src_mode_r[DDCOR_MODE_HI:DDCOR_MODE_LO]);
    wire [1:0] sel_a = sel_r[DDCOR_SEL_A_HI:DDCOR_SEL_A_LO];
    wire [1:0] sel_b = sel_r[DDCOR_SEL_B_HI:DDCOR_SEL_B_LO];
    logic [1:0] pre_a_nxt;
    logic [1:0] pre_b_nxt;

    always_comb begin
        case (src_mode)
            DDCOR_SRC_REG: begin
                pre_a_nxt = sel_a;
                pre_b_nxt = single_channel ? sel_a : sel_b;
            end
            DDCOR_SRC_PINS_AB: begin
                pre_a_nxt = pin_q_r[1:0];
                pre_b_nxt = single_channel ? pin_q_r[1:0] : pin_q_r[3:2];
            end
            DDCOR_SRC_PINS_A: begin
                pre_a_nxt = pin_q_r[1:0];
                pre_b_nxt = pin_q_r[1:0];
            end
            // The reserved mode falls back to the register selection so the NCO stays defined.
            default: begin
                pre_a_nxt = sel_a;
                pre_b_nxt = single_channel ? sel_a : sel_b;
            end
        endcase
    end

    ddcor_nco_t nco_a_nxt;
    ddcor_nco_t nco_b_nxt;
    assign nco_a_nxt = presets_a[pre_a_nxt];
    assign nco_b_nxt = presets_b[pre_b_nxt];

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            active_preset_a <= 2'h0;
            active_preset_b <= 2'h0;
            freq_word_a <= 32'h0;
            phase_word_a <= 32'h0;
            freq_word_b <= 32'h0;
            phase_word_b <= 32'h0;
        end else begin
            active_preset_a <= pre_a_nxt;
            active_preset_b <= pre_b_nxt;
            freq_word_a <= nco_a_nxt.freq;
            phase_word_a <= nco_a_nxt.phase;
            freq_word_b <= nco_b_nxt.freq;
            phase_word_b <= nco_b_nxt.phase;
        end
    end

endmodule

// ===== core/ddcor_pkg.sv
// Package with register map, field layouts and types of the DDC over-range and NCO preset block.
package ddcor_pkg;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [11:0] DDCOR_OFF_THR_I = 12'h211;
    localparam logic [11:0] DDCOR_OFF_THR_Q = 12'h212;
    localparam logic [11:0] DDCOR_OFF_PIN_CFG = 12'h213;
    localparam logic [11:0] DDCOR_OFF_SRC_MODE = 12'h214;
    localparam logic [11:0] DDCOR_OFF_SEL = 12'h215;
    localparam logic [11:0] DDCOR_OFF_BIND = 12'h216;
    localparam logic [11:0] DDCOR_OFF_IRQ_STAT = 12'h220;
    localparam logic [11:0] DDCOR_OFF_IRQ_MASK = 12'h221;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] DDCOR_RST_THR_I = 8'hf2;
    localparam logic [7:0] DDCOR_RST_THR_Q = 8'hab;
    localparam logic [7:0] DDCOR_RST_PIN_CFG = 8'h07;
    localparam logic [7:0] DDCOR_RST_SRC_MODE = 8'h00;
    localparam logic [7:0] DDCOR_RST_SEL = 8'h00;
    localparam logic [7:0] DDCOR_RST_BIND = 8'h02;
    localparam logic [7:0] DDCOR_RST_ZERO = 8'h00;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int DDCOR_PIN_EN_BIT = 3;
    localparam int DDCOR_STRETCH_HI = 2;
    localparam int DDCOR_STRETCH_LO = 0;
    localparam int DDCOR_SEL_A_HI = 1;
    localparam int DDCOR_SEL_A_LO = 0;
    localparam int DDCOR_SEL_B_HI = 3;
    localparam int DDCOR_SEL_B_LO = 2;
    localparam int DDCOR_MODE_HI = 1;
    localparam int DDCOR_MODE_LO = 0;
    localparam int DDCOR_BASE_STRETCH_LOG2 = 3;
    localparam int DDCOR_NUM_FLAGS = 4;
    localparam int DDCOR_NUM_PRESETS = 4;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        DDCOR_SRC_REG,
        DDCOR_SRC_PINS_AB,
        DDCOR_SRC_PINS_A,
        DDCOR_SRC_RSVD
    } ddcor_src_t;

    typedef struct packed {
        logic [11:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } ddcor_bus_t;

    typedef struct packed {
        logic [31:0] freq;
        logic [31:0] phase;
    } ddcor_nco_t;

endpackage

// ===== bench/ddcor_pin_mon.sv
// Board-side watcher that measures how long an over-range pin stays high.
`timescale 1ns/1ps
module ddcor_pin_mon (
    input wire logic ref_clk,
    input wire logic pin,
    output int width
);
    int run = 0;
    // The board only sees whole device clocks, so a width is a count of them.
    always @(posedge ref_clk) begin
        if (pin) begin
            run <= run + 1;
        end else if (run != 0) begin
            width <= run;
            run <= 0;
        end
    end
endmodule

// ===== bench/ddcor_chk_properties.sv
// Checker of the over-range pin and preset selection behaviour.
`timescale 1ns/1ps
module ddcor_chk
    import ddcor_pkg::*;
#(
    parameter int SAMPLE_W = 12
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire ddcor_bus_t bus,
    input wire logic [7:0] rdata,
    input wire logic sample_valid,
    input wire logic signed [SAMPLE_W-1:0] sample_q_a,
    input wire logic [1:0] link_ctrl_a,
    input wire logic range_flag_a_one,
    input wire ddcor_nco_t [DDCOR_NUM_PRESETS-1:0] presets_a,
    input wire logic [1:0] active_preset_a,
    input wire logic [31:0] freq_word_a
);
    // ********
    // Register shadows
    // ********
    logic [7:0] cfg_r, thr_r, mode_r, sel_r;
    wire logic [SAMPLE_W-1:0] abs_q = sample_q_a[SAMPLE_W-1] ? -sample_q_a : sample_q_a;
    wire logic [7:0] mag_q = abs_q[SAMPLE_W-1] ? 8'hff : abs_q[SAMPLE_W-2-:8];
    wire logic det_q = sample_valid && mag_q >= thr_r;
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            cfg_r <= 8'h07;
            thr_r <= 8'hab;
            mode_r <= 8'h00;
            sel_r <= 8'h00;
        end else if (bus.wr) begin
            if (bus.addr == 12'h213) cfg_r <= bus.wdata;
            if (bus.addr == 12'h212) thr_r <= bus.wdata;
            if (bus.addr == 12'h214) mode_r <= bus.wdata;
            if (bus.addr == 12'h215) sel_r <= bus.wdata;
        end
    end
    // ********
    // Properties
    // ********
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (reset);
    AST_LINK_Q: assert property (sample_valid |=> link_ctrl_a[1] == $past(det_q))
        else $error("quadrature flag wrong");
    AST_PIN_OFF: assert property (!$past(cfg_r[3]) |-> !range_flag_a_one)
        else $error("pin high while disabled");
    AST_PIN_ON: assert property (link_ctrl_a[1] && $past(cfg_r[3]) |-> range_flag_a_one)
        else $error("pin missed a detection");
    AST_STRETCH: assert property (
        $rose(range_flag_a_one) && cfg_r[2:0] == 3'h0 |-> (range_flag_a_one || !cfg_r[3])[*8])
        else $error("pulse too short");
    AST_RESTART: assert property ($fell(range_flag_a_one) && $past(cfg_r[3]) |-> !$past(link_ctrl_a[1]))
        else $error("pin fell after a detection");
    AST_RDATA: assert property ($past(bus.rd) && $past(bus.addr) == 12'h212 |-> rdata == $past(thr_r))
        else $error("threshold read wrong");
    AST_SEL_A: assert property (
        mode_r[1:0] == 2'h0 && $stable(mode_r) && $stable(sel_r) |-> active_preset_a == sel_r[1:0])
        else $error("preset A not from register");
    AST_FREQ_A: assert property (!$past(reset) |-> freq_word_a == presets_a[active_preset_a].freq)
        else $error("frequency word wrong");
    CV_PULSE: cover property ($rose(range_flag_a_one));
    CV_MODE2: cover property (mode_r[1:0] == 2'h2);
    CV_READ: cover property ($past(bus.rd));
endmodule
bind ddcor_top ddcor_chk #(.SAMPLE_W(SAMPLE_W)) u_ddcor_chk (.ref_clk, .reset, .bus, .rdata, .sample_valid,
    .sample_q_a, .link_ctrl_a, .range_flag_a_one, .presets_a, .active_preset_a, .freq_word_a);

// ===== bench/ddc_overrange_and_nco_preset_select_tb.sv
// Register-level testbench of the over-range and preset selection block.
`timescale 1ns/1ps
module ddc_overrange_and_nco_preset_select_tb
    import ddcor_pkg::*;
;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic single_channel = 1'b0;
    logic sample_valid = 1'b1;
    ddcor_bus_t bus = '0;
    logic signed [11:0] sample_i_a = '0, sample_q_a = '0, sample_i_b = '0, sample_q_b = '0;
    logic [1:0] preset_pins_a = '0, preset_pins_b = '0, link_ctrl_a, link_ctrl_b, active_preset_a, active_preset_b;
    ddcor_nco_t [3:0] presets_a, presets_b;
    logic [7:0] rdata, channel_binding;
    logic [31:0] freq_word_a, phase_word_a, freq_word_b, phase_word_b;
    logic range_flag_a_zero, range_flag_a_one, range_flag_b_zero, range_flag_b_one, irq;
    int n_errors = 0;
    int comparisons = 0;
    int width;
    logic [1:0] ea, eb;
    logic [7:0] thr_t [4] = '{8'hab, 8'hab, 8'hab, 8'h40};
    logic [11:0] q_t [4] = '{12'h558, 12'h557, 12'haa8, 12'h200};
    logic exp_t [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
    ddcor_top u_ddcor_top (.ref_clk, .reset, .bus, .rdata, .single_channel, .sample_valid, .sample_i_a,
        .sample_q_a, .sample_i_b, .sample_q_b, .link_ctrl_a, .link_ctrl_b, .range_flag_a_zero, .range_flag_a_one,
        .range_flag_b_zero, .range_flag_b_one, .preset_pins_a, .preset_pins_b, .presets_a, .presets_b,
        .active_preset_a, .active_preset_b, .freq_word_a, .phase_word_a, .freq_word_b, .phase_word_b,
        .channel_binding, .irq);
    ddcor_pin_mon u_ddcor_pin_mon (.ref_clk, .pin(range_flag_a_one), .width);
    // ********
    // Tasks
    // ********
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // The wr, rd and samp tasks drive just after a rising edge and return on a falling edge, where outputs have settled.
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        bus <= '0;
        @(negedge ref_clk);
    endtask
    // Read data stands one cycle only, so it is taken on the falling edge inside that cycle.
    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        bus <= '0;
        @(negedge ref_clk);
        check(rdata, exp);
    endtask
    task automatic samp(input logic [11:0] q);
        @(posedge ref_clk);
        {sample_i_a, sample_q_a, sample_i_b, sample_q_b} <= {4{q}};
        @(posedge ref_clk);
        {sample_i_a, sample_q_a, sample_i_b, sample_q_b} <= '0;
        @(negedge ref_clk);
    endtask
    task automatic end_of_test();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // ********
    // Sequence
    // ********
    initial begin
        forever #50 ref_clk = ~ref_clk;
    end
    initial begin
        #200_000;
        n_errors++;
        end_of_test();
    end
    initial begin
        for (int i = 0; i < 4; i++) begin
            presets_a[i] <= {32'ha0 + 32'(i), 32'hc0 + 32'(i)};
            presets_b[i] <= {32'hb0 + 32'(i), 32'hd0 + 32'(i)};
        end
        repeat (5) @(posedge ref_clk);
        reset <= 1'b0;
        preset_pins_a <= 2'd1;
        rd(12'h211, 8'hf2);
        rd(12'h212, 8'hab);
        rd(12'h213, 8'h07);
        rd(12'h214, 8'h00);
        rd(12'h215, 8'h00);
        rd(12'h3ff, 8'h00);
        check(channel_binding, 8'h02);
        for (int k = 0; k < 4; k++) begin
            wr(12'h212, thr_t[k]);
            rd(12'h212, thr_t[k]);
            samp(q_t[k]);
            check(link_ctrl_a, {exp_t[k], 1'b0});
            check(link_ctrl_b, {exp_t[k], 1'b0});
            check(range_flag_a_one, 1'b0);
        end
        @(posedge ref_clk);
        sample_valid <= 1'b0;
        samp(12'h7ff);
        check(link_ctrl_a, 2'b00);
        @(posedge ref_clk);
        sample_valid <= 1'b1;
        check(irq, 1'b0);
        wr(12'h221, 8'h02);
        check(irq, 1'b1);
        wr(12'h220, 8'h02);
        check(irq, 1'b0);
        wr(12'h213, 8'h08);
        samp(12'h7ff);
        check({range_flag_a_zero, range_flag_a_one, range_flag_b_zero, range_flag_b_one}, 4'hf);
        repeat (12) @(negedge ref_clk);
        check(width, 32'd8);
        wr(12'h213, 8'h09);
        samp(12'h800);
        repeat (20) @(negedge ref_clk);
        check(width, 32'd16);
        wr(12'h213, 8'h08);
        samp(12'h7ff);
        repeat (2) @(negedge ref_clk);
        samp(12'h7ff);
        repeat (14) @(negedge ref_clk);
        check(width, 32'd12);
        samp(12'h7ff);
        wr(12'h213, 8'h00);
        @(negedge ref_clk);
        check(range_flag_a_one, 1'b0);
        wr(12'h215, 8'h0b);
        for (int s = 0; s < 2; s++) begin
            for (int m = 0; m < 3; m++) begin
                @(posedge ref_clk);
                single_channel <= s[0];
                wr(12'h214, m[7:0]);
                repeat (2) @(negedge ref_clk);
                ea = (m == 0) ? 2'd3 : 2'd1;
                eb = (s == 1) ? ea : (m == 0) ? 2'd2 : (m == 1) ? 2'd0 : 2'd1;
                check(active_preset_a, ea);
                check(active_preset_b, eb);
                check(freq_word_a, presets_a[ea].freq);
                check(phase_word_a, presets_a[ea].phase);
                check(freq_word_b, presets_b[eb].freq);
                check(phase_word_b, presets_b[eb].phase);
            end
        end
        end_of_test();
    end
endmodule
